// file: core/csp_pkg.sv
// Package for the clock synthesizer serial configuration port
`default_nettype none
package csp_pkg;
  localparam logic [6:0] DEV_ADDR_RST  = 7'h47;
  localparam logic [1:0] DS_RST        = 2'h2;
  localparam logic [7:0] PTR_RST       = 8'h00;
  localparam logic [3:0] BIT_CNT_RST   = 4'h0;
  localparam logic [7:0] LO_RANGE_BASE = 8'h0a;
  localparam logic [7:0] LO_RANGE_TOP  = 8'h17;
  localparam logic [7:0] HI_RANGE_BASE = 8'h40;
  localparam logic [7:0] HI_RANGE_TOP  = 8'h57;
  localparam logic [7:0] ADDR_48       = 8'h48;
  localparam logic [7:0] ADDR_53       = 8'h53;
  localparam logic [7:0] ADDR_54       = 8'h54;
  localparam logic [7:0] ADDR_56       = 8'h56;
  localparam logic [7:0] ADDR_57       = 8'h57;
  // Reset value of the regular registers, arbitrary neutral value
  localparam logic [7:0] REG_RST       = 8'h00;
  // Output register defaults: only the reference copy runs
  localparam logic [7:0] RST_48        = {DS_RST, 6'h00};
  localparam logic [7:0] RST_53        = {6'h00, DS_RST};
  localparam logic [7:0] RST_54        = {DS_RST, 6'h00};
  localparam logic [7:0] RST_56        = {2'h3, DS_RST, 4'h0};
  localparam logic [7:0] RST_57        = {DS_RST, 6'h18};
  localparam int         SYNC_STAGES   = 2;
  // Link bit period, 400 kbit/s at 40 MHz
  localparam int         CLK_HZ        = 40_000_000;
  localparam int         LINK_BPS      = 400_000;
  localparam int         CYC_PER_BIT   = CLK_HZ / LINK_BPS;

  typedef enum {
    CSP_IDLE, CSP_DEVADR, CSP_DEVACK, CSP_REGADR, CSP_REGACK,
    CSP_WDATA, CSP_WACK, CSP_RDATA, CSP_RACK, CSP_SKIP
  } csp_state_t;

  typedef struct packed {
    logic [1:0] clock_output_c;
    logic [1:0] clock_output_d;
    logic [1:0] clock_output_e;
    logic [1:0] clock_output_f;
    logic [1:0] reference_copy_output;
  } csp_drive_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } csp_word_t;
endpackage
`default_nettype wire

// file: core/csp_port.sv
// Two-wire serial configuration slave with register bank
// Summary of operation
// - Output settings change only once all its bytes are stored.
// - Only whole bytes are stored; no partial register update.
// - Drive fields reset to 10 and accept any written value.
// - Port runs reads and writes at up to 400 kbit/s.
// - Write is start, address, direction, ack, pointer, ack, data acks, stop.
// - Device answers to bus address 47H.
// - Data changes only while serial clock is low.
// - Falling data with clock high is a start; address byte follows.
// - Rising data with clock high is a stop, ending the transaction.
// - Device pulls data low on the ninth clock of written bytes.
// - Single write: pointer, ack, one data byte, ack, stop.
// - Burst write acknowledges each byte and increments the pointer.
// - Read framing matches write with direction bit set.
// - Pointer holds last accessed address plus one for current reads.
// - Master not acknowledging, then stopping, ends read transmission.
// - Repeated start after pointer write sets pointer, stores nothing.
// - Master acknowledge continues sequential read with next address.
// - Only two ranges hold real registers; others read zero.
// - Pointer wraps from FFH to 00H.
// - After reset only the reference copy output runs.
// - Drive code 00 is weakest, 11 strongest, passed through as is.
`default_nettype none
module csp_port (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 nrst_in,
  // Two-wire pins
  input  wire logic                 serial_clock_in,
  input  wire logic                 serial_data_pin_in,
  output logic                      serial_data_pin_out,
  output logic                      serial_data_pin_oe_out,
  // Configuration outputs
  output csp_pkg::csp_drive_t       drive_strength_field_out,
  output logic                      reference_copy_run_out,
  output logic                      reg_update_out
);
  // Pin synchronisers
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_q;
  logic       sda_q;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], serial_clock_in};
      sda_sync_q <= {sda_sync_q[0], serial_data_pin_in};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  wire scl_s   = scl_sync_q[1];
  wire sda_s   = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_ev  = scl_s & scl_q & ~sda_q & sda_s;

  csp_pkg::csp_state_t state_q, state_d;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic       rw_q;
  logic       oe_q;
  logic       mack_q;
  logic [7:0] regs_q [0:255];

  // Two-entry buffer between the byte receiver and the register bank
  csp_pkg::csp_word_t buf_q [0:1];
  logic [1:0] buf_cnt_q;
  logic       buf_wr_q, buf_rd_q;
  logic       in_valid;
  wire        in_ready  = (buf_cnt_q != 2'h2);
  wire        out_valid = (buf_cnt_q != 2'h0);
  wire        out_ready = 1'b1;
  csp_pkg::csp_word_t in_word;

  wire [7:0] next_shift = {shift_q[6:0], sda_s};
  wire       last_bit   = (bit_cnt_q == 4'h7);
  wire       addr_hit   = (next_shift[7:1] == csp_pkg::DEV_ADDR_RST);
  wire [7:0] ptr_inc    = ptr_q + 8'h01;
  wire       in_lo      = (ptr_q >= csp_pkg::LO_RANGE_BASE) &&
                          (ptr_q <= csp_pkg::LO_RANGE_TOP);
  wire       in_hi      = (ptr_q >= csp_pkg::HI_RANGE_BASE) &&
                          (ptr_q <= csp_pkg::HI_RANGE_TOP);
  wire       real_reg   = in_lo | in_hi;
  wire [7:0] rd_byte    = real_reg ? regs_q[ptr_q] : 8'h00;
  // Ack states span the whole ninth clock: entered at the rise of the eighth,
  // left at the fall that ends the ninth, or on a start or stop
  wire       ack_phase  = (state_q == csp_pkg::CSP_DEVACK) ||
                          (state_q == csp_pkg::CSP_REGACK) ||
                          (state_q == csp_pkg::CSP_WACK);
  wire       ack_done   = scl_fall && (bit_cnt_q == 4'h1);

  always_comb begin
    state_d  = state_q;
    in_valid = 1'b0;
    in_word  = '{addr: ptr_q, data: next_shift};
    case (state_q)
      csp_pkg::CSP_IDLE:   state_d = state_q;
      csp_pkg::CSP_DEVADR:
        if (scl_rise && last_bit)
          state_d = addr_hit ? csp_pkg::CSP_DEVACK
                             : csp_pkg::CSP_SKIP;
      csp_pkg::CSP_DEVACK:
        if (ack_done)
          state_d = rw_q ? csp_pkg::CSP_RDATA
                         : csp_pkg::CSP_REGADR;
      csp_pkg::CSP_REGADR:
        if (scl_rise && last_bit) state_d = csp_pkg::CSP_REGACK;
      csp_pkg::CSP_REGACK:
        if (ack_done) state_d = csp_pkg::CSP_WDATA;
      csp_pkg::CSP_WDATA:
        if (scl_rise && last_bit && in_ready) begin
          state_d  = csp_pkg::CSP_WACK;
          in_valid = 1'b1;
        end
      csp_pkg::CSP_WACK:
        if (ack_done) state_d = csp_pkg::CSP_WDATA;
      csp_pkg::CSP_RDATA:
        if (scl_fall && last_bit) state_d = csp_pkg::CSP_RACK;
      csp_pkg::CSP_RACK:
        if (scl_fall)
          state_d = mack_q ? csp_pkg::CSP_RDATA
                           : csp_pkg::CSP_SKIP;
      csp_pkg::CSP_SKIP:   state_d = state_q;
      default:             state_d = csp_pkg::CSP_IDLE;
    endcase
    if (start_ev) state_d = csp_pkg::CSP_DEVADR;
    if (stop_ev) state_d = csp_pkg::CSP_IDLE;
  end

  // Bit counting; counter resets on each byte boundary
  wire byte_phase = (state_q == csp_pkg::CSP_DEVADR) ||
                    (state_q == csp_pkg::CSP_REGADR) ||
                    (state_q == csp_pkg::CSP_WDATA);
  always_ff @(posedge clk_in) begin
    if (!nrst_in || start_ev || state_d != state_q) begin
      bit_cnt_q <= csp_pkg::BIT_CNT_RST;
    end else if (byte_phase && scl_rise) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (ack_phase && scl_fall) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (state_q == csp_pkg::CSP_RDATA && scl_fall) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // Shift register: receive on rise, transmit shifts on fall
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      shift_q <= 8'h00;
    end else if (byte_phase && scl_rise) begin
      shift_q <= next_shift;
    end else if (state_d == csp_pkg::CSP_RDATA &&
                 state_q != csp_pkg::CSP_RDATA) begin
      shift_q <= rd_byte;
    end else if (state_q == csp_pkg::CSP_RDATA && scl_fall) begin
      shift_q <= {shift_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_q <= csp_pkg::CSP_IDLE;
      rw_q    <= 1'b0;
      mack_q  <= 1'b0;
      ptr_q   <= csp_pkg::PTR_RST;
    end else begin
      state_q <= state_d;
      if (state_q == csp_pkg::CSP_DEVADR && scl_rise && last_bit)
        rw_q <= sda_s;
      if (state_q == csp_pkg::CSP_RACK && scl_rise)
        mack_q <= ~sda_s;
      if (state_q == csp_pkg::CSP_REGADR && scl_rise && last_bit)
        ptr_q <= next_shift;
      else if (in_valid)
        ptr_q <= ptr_inc;
      else if (state_q == csp_pkg::CSP_RDATA && scl_fall && last_bit)
        ptr_q <= ptr_inc;
    end
  end

  // Data pin drive, changed only after a falling clock or on a start or stop
  // Shift register moves on that same fall, so the next bit is [6]
  logic oe_d;
  always_comb begin
    case (state_d)
      csp_pkg::CSP_DEVACK,
      csp_pkg::CSP_REGACK,
      csp_pkg::CSP_WACK:  oe_d = 1'b1;
      csp_pkg::CSP_RDATA: oe_d = ~(state_q == csp_pkg::CSP_RDATA ?
                                   shift_q[6] : rd_byte[7]);
      default:            oe_d = 1'b0;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) oe_q <= 1'b0;
    else if (scl_fall || stop_ev || start_ev) oe_q <= oe_d;
  end
  assign serial_data_pin_oe_out = oe_q;
  assign serial_data_pin_out    = 1'b0;

  // Buffer: filled by the receiver, drained into the register bank
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      buf_cnt_q <= 2'h0;
      buf_wr_q  <= 1'b0;
      buf_rd_q  <= 1'b0;
    end else begin
      if (in_valid && in_ready) begin
        buf_q[buf_wr_q] <= in_word;
        buf_wr_q        <= ~buf_wr_q;
      end
      if (out_valid && out_ready) buf_rd_q <= ~buf_rd_q;
      buf_cnt_q <= buf_cnt_q + {1'b0, in_valid && in_ready}
                             - {1'b0, out_valid && out_ready};
    end
  end

  csp_pkg::csp_word_t head;
  assign head = buf_q[buf_rd_q];
  wire head_real = ((head.addr >= csp_pkg::LO_RANGE_BASE) &&
                    (head.addr <= csp_pkg::LO_RANGE_TOP)) ||
                   ((head.addr >= csp_pkg::HI_RANGE_BASE) &&
                    (head.addr <= csp_pkg::HI_RANGE_TOP));

  // Register bank; outside ranges writes are dropped
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 256; i++) regs_q[i] <= csp_pkg::REG_RST;
      regs_q[csp_pkg::ADDR_48] <= csp_pkg::RST_48;
      regs_q[csp_pkg::ADDR_53] <= csp_pkg::RST_53;
      regs_q[csp_pkg::ADDR_54] <= csp_pkg::RST_54;
      regs_q[csp_pkg::ADDR_56] <= csp_pkg::RST_56;
      regs_q[csp_pkg::ADDR_57] <= csp_pkg::RST_57;
      reg_update_out <= 1'b0;
    end else begin
      reg_update_out <= out_valid && head_real;
      if (out_valid && head_real)
        regs_q[head.addr] <= head.data;
    end
  end

  // Drive codes pass through unchanged, 00 weakest to 11 strongest
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      drive_strength_field_out <= {5{csp_pkg::DS_RST}};
      reference_copy_run_out   <= 1'b1;
    end else begin
      drive_strength_field_out <= '{
        clock_output_c:        regs_q[csp_pkg::ADDR_48][7:6],
        clock_output_d:        regs_q[csp_pkg::ADDR_53][1:0],
        clock_output_e:        regs_q[csp_pkg::ADDR_54][7:6],
        clock_output_f:        regs_q[csp_pkg::ADDR_56][5:4],
        reference_copy_output: regs_q[csp_pkg::ADDR_57][7:6]};
      reference_copy_run_out <= regs_q[csp_pkg::ADDR_57][5:0] != 6'h0c;
    end
  end
endmodule
`default_nettype wire

// file: dv/csp_host.sv
// Two-wire bus master model, 8 clocks per bit
`default_nettype none
module csp_host (
  // Clock
  input  wire logic clk_in,
  // Bus lines
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock stands high outside frames
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    sda_oe_out <= ~b;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    r = sda_in;
    tick(2);
    scl_out <= 1'b0;
  endtask
  task automatic start();
    tick(2);
    sda_oe_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    sda_oe_out <= 1'b1;
    tick(2);
    scl_out <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_oe_out <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    sda_oe_out <= 1'b0;
    tick(8);
  endtask
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(m, a);
  endtask
endmodule
`default_nettype wire

// file: dv/csp_port_bench.sv
// Self-checking bench for the serial configuration port
`default_nettype none
module csp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk_in = 1'b0;
  logic                     nrst_in = 1'b0;
  wire                      scl;
  wire                      host_oe;
  wire                      dut_do;
  wire                      dut_oe;
  wire                      sda;
  wire                      upd;
  wire                      ref_run;
  wire csp_pkg::csp_drive_t drv;
  int                       err_total = 0;
  int                       samples_checked = 0;
  int                       upd_cnt = 0;
  logic [7:0]               q;
  logic                     a;
  always #12.5 clk_in = ~clk_in;
  // Pull-up unless a party pulls low
  assign sda = ~host_oe & (dut_oe ? dut_do : 1'b1);
  always @(posedge clk_in) if (upd === 1'b1) upd_cnt++;
  csp_port dut (.clk_in(clk_in), .nrst_in(nrst_in), .serial_clock_in(scl),
    .serial_data_pin_in(sda), .serial_data_pin_out(dut_do),
    .serial_data_pin_oe_out(dut_oe), .drive_strength_field_out(drv),
    .reference_copy_run_out(ref_run), .reg_update_out(upd));
  csp_host host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_out(host_oe));
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] d);
    host.xfer(d, 1'b1, q, a);
    chk("slave ack", 10'h0, {9'h0, a});
  endtask
  task automatic rb(input logic m, input logic [7:0] e);
    host.xfer(8'hff, m, q, a);
    chk("read byte", {2'h0, e}, {2'h0, q});
  endtask
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_reset();
    chk("drive reset", 10'h2aa, drv);
    chk("ref run", 10'h1, {9'h0, ref_run});
    chk("data oe", 10'h0, {9'h0, dut_oe});
  endtask
  task automatic t_single();
    int n;
    n = upd_cnt;
    host.start();
    wb(8'h8e);
    wb(8'h48);
    wb(8'hc9);
    host.stop();
    chk("drive c", 10'h3aa, drv);
    chk("updates", 10'h1, 10'(upd_cnt - n));
  endtask
  task automatic t_bad();
    host.start();
    host.xfer(8'h8c, 1'b1, q, a);
    chk("no ack", 10'h1, {9'h0, a});
    host.xfer(8'h48, 1'b1, q, a);
    host.xfer(8'h00, 1'b1, q, a);
    host.stop();
    chk("drive kept", 10'h3aa, drv);
  endtask
  task automatic t_burst();
    host.start();
    wb(8'h8e);
    wb(8'h53);
    wb(8'h01);
    wb(8'h40);
    wb(8'h00);
    wb(8'hf0);
    wb(8'h0c);
    host.stop();
    chk("drive burst", 10'h35c, drv);
    chk("ref off", 10'h0, {9'h0, ref_run});
  endtask
  task automatic t_reads();
    host.start();
    wb(8'h8e);
    wb(8'h54);
    host.start();
    wb(8'h8f);
    rb(1'b0, 8'h40);
    rb(1'b0, 8'h00);
    rb(1'b1, 8'hf0);
    host.stop();
    host.start();
    wb(8'h8f);
    rb(1'b1, 8'h0c);
    host.stop();
  endtask
  task automatic t_wrap();
    int n;
    n = upd_cnt;
    host.start();
    wb(8'h8e);
    wb(8'hff);
    wb(8'haa);
    wb(8'h33);
    host.stop();
    chk("ignored writes", 10'h0, 10'(upd_cnt - n));
    host.start();
    wb(8'h8e);
    wb(8'h0a);
    wb(8'h5a);
    host.stop();
    host.start();
    wb(8'h8e);
    wb(8'hff);
    host.start();
    wb(8'h8f);
    for (int i = 0; i < 11; i++) rb(1'b0, 8'h00);
    rb(1'b1, 8'h5a);
    host.stop();
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_single();
    t_bad();
    t_burst();
    t_reads();
    t_wrap();
    wrap_up();
  end
  // Run needs about 83 us of bus traffic
  initial begin
    #400us;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire

// file: dv/csp_props.sv
// Concurrent checks on the serial configuration port pins
`default_nettype none
module csp_props (
  // Clock and reset
  input wire logic                clk_in,
  input wire logic                nrst_in,
  // Bus pins
  input wire logic                serial_clock_in,
  input wire logic                serial_data_pin_in,
  input wire logic                serial_data_pin_out,
  input wire logic                serial_data_pin_oe_out,
  // Configuration outputs
  input wire csp_pkg::csp_drive_t drive_strength_field_out,
  input wire logic                reference_copy_run_out,
  input wire logic                reg_update_out
);
  logic [3:0] hi_q;
  logic [3:0] hi_d;
  // Long clock-high stretch means the bus is idle
  assign hi_d = !serial_clock_in ? 4'h0 : (hi_q == 4'hf ? hi_q : hi_q + 4'h1);
  always_ff @(posedge clk_in) begin
    hi_q <= nrst_in ? hi_d : 4'h0;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  pin_low_a: assert property (serial_data_pin_out == 1'b0)
    else $error("data pin output not low");
  reset_def_a: assert property ($rose(nrst_in) |->
    !serial_data_pin_oe_out && drive_strength_field_out == 10'h2aa &&
    reference_copy_run_out && !reg_update_out)
    else $error("reset defaults wrong");
  upd_pulse_a: assert property (reg_update_out |=> !reg_update_out)
    else $error("update pulse too long");
  drive_cause_a: assert property ($changed(drive_strength_field_out) |->
    $past(reg_update_out) || $past(reg_update_out, 2))
    else $error("drive changed without update");
  ref_cause_a: assert property ($changed(reference_copy_run_out) |->
    $past(reg_update_out) || $past(reg_update_out, 2))
    else $error("ref run changed without update");
  oe_rise_low_a: assert property ($rose(serial_data_pin_oe_out) |->
    !serial_clock_in)
    else $error("data driven while clock high");
  oe_hold_high_a: assert property (serial_clock_in && $past(serial_clock_in)
    |-> $stable(serial_data_pin_oe_out))
    else $error("data moved while clock high");
  idle_free_a: assert property (hi_q == 4'hf |-> !serial_data_pin_oe_out)
    else $error("data held on idle bus");
endmodule
bind csp_port csp_props u_props (
  .clk_in(clk_in), .nrst_in(nrst_in), .serial_clock_in(serial_clock_in),
  .serial_data_pin_in(serial_data_pin_in),
  .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe_out(serial_data_pin_oe_out),
  .drive_strength_field_out(drive_strength_field_out),
  .reference_copy_run_out(reference_copy_run_out),
  .reg_update_out(reg_update_out));
`default_nettype wire
